// ---- design/amb_comp_pkg.sv ----
// constants shared by the ambient compensation register bank
package amb_comp_pkg;
  // ----------------------------------------
  // register offsets (16-bit words)
  // ----------------------------------------
  localparam logic [9:0] OFS_SYS_CTRL = 10'h000;
  localparam logic [9:0] OFS_CTRL_A = 10'h002;
  localparam logic [9:0] OFS_CTRL_B = 10'h003;
  localparam logic [9:0] OFS_RECAL_TIMES = 10'h004;
  localparam logic [9:0] OFS_LOW_IRQ_PIN = 10'h005;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SYS_SOFT_RESET_POS = 10;
  localparam int SYS_IRQ_POL_POS = 11;
  localparam int A_SKIP_LSB = 0;
  localparam int A_FP_HOLD_LSB = 4;
  localparam int A_LP_HOLD_LSB = 8;
  localparam int A_TIMEOUT_LSB = 12;
  localparam int A_FORCE_CAL_POS = 14;
  localparam int A_RESTART_POS = 15;
  localparam int B_LEVEL_LSB = 0;
  localparam int B_RATE_LSB = 8;
  localparam int B_SLOW_LSB = 14;
  localparam int T_FP_LSB = 0;
  localparam int T_LP_LSB = 10;
  localparam int P_SETUP_LSB = 12;
  localparam int P_TRIG_LSB = 14;
  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [3:0] RST_SKIP = 4'h0;
  localparam logic [3:0] RST_FP_HOLD = 4'hf;
  localparam logic [3:0] RST_LP_HOLD = 4'hf;
  localparam logic [1:0] RST_TIMEOUT = 2'h0;
  localparam logic [7:0] RST_LEVEL = 8'h40;
  localparam logic [5:0] RST_RATE = 6'h01;
  localparam logic [1:0] RST_SLOW = 2'h0;
  localparam logic [9:0] RST_FP_RECAL = 10'h3ff;
  localparam logic [5:0] RST_LP_RECAL = 6'h3f;
  // ----------------------------------------
  // counts and encodings
  // ----------------------------------------
  localparam logic [3:0] SKIP_MAX_CODE = 4'hb;
  localparam logic [3:0] SKIP_MAX_SEQS = 4'h8;
  localparam int FP_HOLD_SHIFT = 4;
  localparam int LP_HOLD_SHIFT = 2;
  localparam logic [1:0] PIN_OFF = 2'h0;
  localparam logic [1:0] PIN_INPUT = 2'h1;
  localparam logic [1:0] PIN_OUT_LOW = 2'h2;
  localparam logic [1:0] PIN_OUT_HIGH = 2'h3;
  localparam logic [1:0] TRIG_LOW_LEVEL = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_HIGH_LEVEL = 2'h3;
  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_ADDR = 3'b001,
    SER_ACK_WAIT = 3'b010,
    SER_ACK = 3'b011,
    SER_RX = 3'b100,
    SER_TX = 3'b101,
    SER_TX_DONE = 3'b110,
    SER_MACK = 3'b111
  } ser_state_t;
endpackage

// ---- design/pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // raw pins and filtered levels
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_clean
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, clean_q;
  logic [WIDTH-1:0] clean_d;

  // a level is taken only once stage two and three agree, so one-cycle glitches die here
  always_comb
  begin
    clean_d = clean_q;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_q[i] == s3_q[i])
        clean_d[i] = s3_q[i];
    end
  end

  // idle bus level is high, so reset to ones avoids a false start condition
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      clean_q <= '1;
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end

  assign pin_clean = clean_q;
endmodule

// ---- design/seq_countdown.sv ----
// sequence-counting down timer with load, clear and expiry pulse
`timescale 1ns/1ps
module seq_countdown #(
  parameter int WIDTH = 10
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic tick,
  // status
  output logic busy,
  output logic expire
);
  logic [WIDTH-1:0] count_q, count_d;
  logic busy_q, busy_d, expire_q, expire_d;

  initial
  begin
    if (WIDTH < 2) $error("seq_countdown needs WIDTH >= 2");
  end

  // load beats tick so a fresh event restarts the full period, but clear beats load and holds the count at zero
  always_comb
  begin
    count_d = count_q;
    expire_d = 1'b0;
    if (clear)
      count_d = '0;
    else if (load)
      count_d = load_value;
    else if (tick && count_q != '0)
    begin
      count_d = count_q - 1'b1;
      expire_d = (count_q == {{(WIDTH-1){1'b0}}, 1'b1});
    end
    busy_d = (count_d != '0);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
      busy_q <= 1'b0;
      expire_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      busy_q <= busy_d;
      expire_q <= expire_d;
    end
  end

  assign busy = busy_q;
  assign expire = expire_q;
endmodule

// ---- design/ambient_comp_ctrl_regs.sv ----
// ambient compensation control registers behind a two-wire serial slave
`timescale 1ns/1ps
module ambient_comp_ctrl_regs
  import amb_comp_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a, // arbitrary default device address
  parameter int STAGES = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // two-wire serial port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // sequencer and calibration side
  input wire logic sequence_done,
  input wire logic low_power_mode,
  input wire logic near_detect,
  output logic fast_filter_admit,
  output logic cal_hold,
  output logic power_fallback,
  output logic force_recal_all,
  output logic sequence_restart,
  output logic [11:0] near_recal_level_eff,
  output logic [9:0] near_detect_rate_eff,
  output logic [1:0] slow_filter_update_level,
  output logic [9:0] full_power_recal_time,
  output logic [5:0] low_power_recal_time,
  // interrupt
  input wire logic [STAGES-1:0] stage_low_exceeded,
  input wire logic other_irq,
  output logic irq_pin,
  // general-purpose pin
  input wire logic gpio_in,
  input wire logic gpio_assert,
  output logic gpio_out,
  output logic gpio_oe,
  output logic gpio_event
);
  import amb_comp_pkg::*;

  initial
  begin
    if (STAGES != 8) $error("ambient_comp_ctrl_regs supports exactly 8 stages");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic scl_f, sda_f, gpio_f;

  pin_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin_raw({scl_in, sda_in, gpio_in}),
    .pin_clean({scl_f, sda_f, gpio_f})
  );

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  ser_state_t st_q, st_d;
  logic scl_p_q, sda_p_q, gpio_p_q;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, hold_q, hold_d, tx_q, tx_d;
  logic [1:0] idx_q, idx_d;
  logic rw_q, rw_d, oe_q, oe_d;
  logic [9:0] ptr_q, ptr_d;
  logic we_d, we_q;
  logic [15:0] wd_d, wd_q;
  logic [9:0] wa_d, wa_q;
  logic rise, fall, start_c, stop_c;
  logic [7:0] byte_in;

  assign rise = scl_f & ~scl_p_q;
  assign fall = ~scl_f & scl_p_q;
  assign start_c = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_c = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign byte_in = {sh_q[6:0], sda_f};

  // register contents as seen by a read
  function automatic logic [15:0] read_word(input logic [9:0] a, input logic [15:0] s,
                                             input logic [15:0] ca, input logic [15:0] cb,
                                             input logic [15:0] ct, input logic [15:0] cp);
    case (a)
      OFS_SYS_CTRL: read_word = s;
      OFS_CTRL_A: read_word = ca;
      OFS_CTRL_B: read_word = cb;
      OFS_RECAL_TIMES: read_word = ct;
      OFS_LOW_IRQ_PIN: read_word = cp;
      default: read_word = 16'h0000;
    endcase
  endfunction

  logic [15:0] rd_word;

  // protocol engine: start/stop override any state, data moves on clock edges
  always_comb
  begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    hold_d = hold_q;
    tx_d = tx_q;
    idx_d = idx_q;
    rw_d = rw_q;
    oe_d = oe_q;
    ptr_d = ptr_q;
    we_d = 1'b0;
    wd_d = wd_q;
    wa_d = wa_q;
    if (start_c)
    begin
      st_d = SER_ADDR;
      bit_d = 3'h0;
      idx_d = 2'h0;
      oe_d = 1'b0;
    end
    else if (stop_c)
    begin
      st_d = SER_IDLE;
      oe_d = 1'b0;
    end
    else
    begin
      case (st_q)
        SER_IDLE: st_d = SER_IDLE;
        SER_ADDR:
          if (rise)
          begin
            sh_d = byte_in;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
              rw_d = sda_f;
              st_d = (sh_q[6:0] == SLAVE_ADDR) ? SER_ACK_WAIT : SER_IDLE;
            end
          end
        SER_ACK_WAIT:
          if (fall)
          begin
            oe_d = 1'b1; // pull low for acknowledge
            st_d = SER_ACK;
          end
        SER_ACK:
          if (fall)
          begin
            bit_d = 3'h0;
            if (rw_q)
            begin
              tx_d = idx_q[0] ? rd_word[7:0] : rd_word[15:8];
              oe_d = ~tx_d[7];
              st_d = SER_TX;
            end
            else
            begin
              oe_d = 1'b0;
              st_d = SER_RX;
            end
          end
        SER_RX:
          if (rise)
          begin
            sh_d = byte_in;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
              st_d = SER_ACK_WAIT;
              case (idx_q)
                2'h0: ptr_d = {byte_in[1:0], ptr_q[7:0]};
                2'h1: ptr_d = {ptr_q[9:8], byte_in};
                2'h2: hold_d = byte_in;
                default:
                begin
                  we_d = 1'b1;
                  wa_d = ptr_q;
                  wd_d = {hold_q, byte_in}; // high byte first
                  ptr_d = ptr_q + 10'h001;
                end
              endcase
              idx_d = (idx_q == 2'h3) ? 2'h2 : idx_q + 2'h1;
            end
          end
        SER_TX:
          if (rise)
          begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7)
              st_d = SER_TX_DONE;
          end
          else if (fall)
            oe_d = ~tx_q[3'h7 - bit_q];
        SER_TX_DONE:
          if (fall)
          begin
            oe_d = 1'b0;
            st_d = SER_MACK;
          end
        SER_MACK:
          if (rise)
          begin
            if (idx_q[0])
              ptr_d = ptr_q + 10'h001;
            idx_d = {1'b0, ~idx_q[0]};
            // master acknowledge keeps reading, release ends the read
            st_d = sda_f ? SER_IDLE : SER_ACK;
          end
        default: st_d = SER_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_q <= SER_IDLE;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      hold_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= 2'h0;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      ptr_q <= 10'h000;
      we_q <= 1'b0;
      wd_q <= 16'h0000;
      wa_q <= 10'h000;
    end
    else
    begin
      st_q <= st_d;
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      bit_q <= bit_d;
      sh_q <= sh_d;
      hold_q <= hold_d;
      tx_q <= tx_d;
      idx_q <= idx_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
      ptr_q <= ptr_d;
      we_q <= we_d;
      wd_q <= wd_d;
      wa_q <= wa_d;
    end
  end

  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe = oe_q;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic pol_q, pol_d, srst_q, srst_d, rst_q, rst_d, fcal_q, fcal_d;
  logic [3:0] skip_q, skip_d, fph_q, fph_d, lph_q, lph_d;
  logic [1:0] tmo_q, tmo_d, slow_q, slow_d, setup_q, setup_d, trig_q, trig_d;
  logic [7:0] lvl_q, lvl_d, lowen_q, lowen_d;
  logic [5:0] rate_q, rate_d, lprc_q, lprc_d;
  logic [9:0] fprc_q, fprc_d;

  assign rd_word = read_word(ptr_q,
    16'(pol_q) << SYS_IRQ_POL_POS,
    {1'b0, fcal_q, tmo_q, lph_q, fph_q, skip_q},   // restart bit reads zero
    {slow_q, rate_q, lvl_q},
    {lprc_q, fprc_q},
    {trig_q, setup_q, 4'h0, lowen_q});

  // decode a pending write; soft reset wins over everything
  always_comb
  begin
    pol_d = pol_q;
    skip_d = skip_q;
    fph_d = fph_q;
    lph_d = lph_q;
    tmo_d = tmo_q;
    fcal_d = fcal_q;
    lvl_d = lvl_q;
    rate_d = rate_q;
    slow_d = slow_q;
    fprc_d = fprc_q;
    lprc_d = lprc_q;
    lowen_d = lowen_q;
    setup_d = setup_q;
    trig_d = trig_q;
    srst_d = 1'b0;
    rst_d = 1'b0;
    if (srst_q)
    begin
      pol_d = 1'b0;
      skip_d = RST_SKIP;
      fph_d = RST_FP_HOLD;
      lph_d = RST_LP_HOLD;
      tmo_d = RST_TIMEOUT;
      fcal_d = 1'b0;
      lvl_d = RST_LEVEL;
      rate_d = RST_RATE;
      slow_d = RST_SLOW;
      fprc_d = RST_FP_RECAL;
      lprc_d = RST_LP_RECAL;
      lowen_d = 8'h00;
      setup_d = PIN_OFF;
      trig_d = TRIG_LOW_LEVEL;
    end
    else if (we_q)
    begin
      case (wa_q)
        OFS_SYS_CTRL:
        begin
          pol_d = wd_q[SYS_IRQ_POL_POS];
          srst_d = wd_q[SYS_SOFT_RESET_POS];
        end
        OFS_CTRL_A:
        begin
          skip_d = wd_q[A_SKIP_LSB +: 4];
          fph_d = wd_q[A_FP_HOLD_LSB +: 4];
          lph_d = wd_q[A_LP_HOLD_LSB +: 4];
          tmo_d = wd_q[A_TIMEOUT_LSB +: 2];
          fcal_d = wd_q[A_FORCE_CAL_POS];
          rst_d = wd_q[A_RESTART_POS];
        end
        OFS_CTRL_B:
        begin
          lvl_d = wd_q[B_LEVEL_LSB +: 8];
          rate_d = wd_q[B_RATE_LSB +: 6];
          slow_d = wd_q[B_SLOW_LSB +: 2];
        end
        OFS_RECAL_TIMES:
        begin
          fprc_d = wd_q[T_FP_LSB +: 10];
          lprc_d = wd_q[T_LP_LSB +: 6];
        end
        OFS_LOW_IRQ_PIN:
        begin
          lowen_d = wd_q[7:0]; // bits 11:8 dropped
          setup_d = wd_q[P_SETUP_LSB +: 2];
          trig_d = wd_q[P_TRIG_LSB +: 2];
        end
        default: pol_d = pol_q; // unmapped writes are ignored
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pol_q <= 1'b0;
      srst_q <= 1'b0;
      rst_q <= 1'b0;
      skip_q <= RST_SKIP;
      fph_q <= RST_FP_HOLD;
      lph_q <= RST_LP_HOLD;
      tmo_q <= RST_TIMEOUT;
      fcal_q <= 1'b0;
      lvl_q <= RST_LEVEL;
      rate_q <= RST_RATE;
      slow_q <= RST_SLOW;
      fprc_q <= RST_FP_RECAL;
      lprc_q <= RST_LP_RECAL;
      lowen_q <= 8'h00;
      setup_q <= PIN_OFF;
      trig_q <= TRIG_LOW_LEVEL;
    end
    else
    begin
      pol_q <= pol_d;
      srst_q <= srst_d;
      rst_q <= rst_d;
      skip_q <= skip_d;
      fph_q <= fph_d;
      lph_q <= lph_d;
      tmo_q <= tmo_d;
      fcal_q <= fcal_d;
      lvl_q <= lvl_d;
      rate_q <= rate_d;
      slow_q <= slow_d;
      fprc_q <= fprc_d;
      lprc_q <= lprc_d;
      lowen_q <= lowen_d;
      setup_q <= setup_d;
      trig_q <= trig_d;
    end
  end

  assign force_recal_all = fcal_q;
  assign sequence_restart = rst_q;
  assign near_recal_level_eff = {lvl_q, 4'h0};
  assign near_detect_rate_eff = {rate_q, 4'h0};
  assign slow_filter_update_level = slow_q;
  assign full_power_recal_time = fprc_q;
  assign low_power_recal_time = lprc_q;

  // ----------------------------------------
  // fast filter admission
  // ----------------------------------------
  logic [3:0] gap_q, gap_d, skip_n;
  logic adm_q, adm_d;

  // codes of SKIP_MAX_CODE - 3 (8) and above are clamped to SKIP_MAX_SEQS rather than trusted
  assign skip_n = (skip_q >= SKIP_MAX_CODE - 4'h3) ? SKIP_MAX_SEQS : skip_q;

  always_comb
  begin
    gap_d = gap_q;
    adm_d = 1'b0;
    if (srst_q || rst_q)
      gap_d = 4'h0;
    else if (sequence_done)
    begin
      if (gap_q == 4'h0)
      begin
        adm_d = 1'b1;
        gap_d = skip_n;
      end
      else
        gap_d = gap_q - 4'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      gap_q <= 4'h0;
      adm_q <= 1'b0;
    end
    else
    begin
      gap_q <= gap_d;
      adm_q <= adm_d;
    end
  end

  assign fast_filter_admit = adm_q;

  // ----------------------------------------
  // calibration hold and power fallback
  // ----------------------------------------
  logic [9:0] hold_len, fall_len;

  assign hold_len = low_power_mode ? (10'(lph_q) << LP_HOLD_SHIFT)
                                   : (10'(fph_q) << FP_HOLD_SHIFT);
  // 16 x count x (5 + code) / 4 gives the 1.25 to 2.00 scales exactly
  assign fall_len = 10'(fph_q) * (10'h005 + 10'(tmo_q)) << 2;

  seq_countdown #(.WIDTH(10)) u_hold (
    .clock(clock),
    .rst_n(rst_n),
    .clear(srst_q),
    .load(near_detect),
    .load_value(hold_len),
    .tick(sequence_done),
    .busy(cal_hold),
    .expire()
  );

  seq_countdown #(.WIDTH(10)) u_fallback (
    .clock(clock),
    .rst_n(rst_n),
    .clear(srst_q | low_power_mode),
    .load(near_detect),
    .load_value(fall_len),
    .tick(sequence_done),
    .busy(),
    .expire(power_fallback)
  );

  // ----------------------------------------
  // interrupt and general-purpose pin
  // ----------------------------------------
  logic irq_q, irq_d, gout_q, gout_d, goe_q, goe_d, gev_q, gev_d;

  always_comb
  begin
    // level combination: sources stay asserted while their condition holds
    irq_d = |(stage_low_exceeded & lowen_q) | other_irq;
    irq_d = pol_q ? irq_d : ~irq_d;
    goe_d = (setup_q == PIN_OUT_LOW) || (setup_q == PIN_OUT_HIGH);
    gout_d = (setup_q == PIN_OUT_HIGH) ? gpio_assert : ~gpio_assert;
    gev_d = 1'b0;
    if (setup_q == PIN_INPUT)
    begin
      case (trig_q)
        TRIG_LOW_LEVEL: gev_d = ~gpio_f;
        TRIG_RISE: gev_d = gpio_f & ~gpio_p_q;
        TRIG_FALL: gev_d = ~gpio_f & gpio_p_q;
        default: gev_d = gpio_f;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b1; // idle high under default active-low polarity
      gout_q <= 1'b0;
      goe_q <= 1'b0;
      gev_q <= 1'b0;
      gpio_p_q <= 1'b1;
    end
    else
    begin
      irq_q <= irq_d;
      gout_q <= gout_d;
      goe_q <= goe_d;
      gev_q <= gev_d;
      gpio_p_q <= gpio_f;
    end
  end

  assign irq_pin = irq_q;
  assign gpio_out = gout_q;
  assign gpio_oe = goe_q;
  assign gpio_event = gev_q;
endmodule

// ---- verif/amb_comp_props.sv ----
// assertions on the ambient compensation register bank ports
`timescale 1ns/1ps
module amb_comp_props #(
  parameter int STAGES = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // sequence side
  input wire logic sequence_done,
  input wire logic low_power_mode,
  input wire logic near_detect,
  input wire logic fast_filter_admit,
  input wire logic cal_hold,
  input wire logic power_fallback,
  input wire logic sequence_restart,
  input wire logic [11:0] near_recal_level_eff,
  input wire logic [9:0] near_detect_rate_eff,
  // interrupt
  input wire logic [STAGES-1:0] stage_low_exceeded,
  input wire logic other_irq,
  input wire logic irq_pin
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  property p_admit; fast_filter_admit |-> $past(sequence_done); endproperty
  a_admit: assert property (p_admit) else $error("admit without a sequence");
  property p_hold_on; near_detect |=> cal_hold; endproperty
  a_hold_on: assert property (p_hold_on) else $error("hold did not start");
  property p_hold_rise; $rose(cal_hold) |-> $past(near_detect); endproperty
  a_hold_rise: assert property (p_hold_rise) else $error("hold rose without detect");
  property p_fall; power_fallback |-> $past(sequence_done) && !$past(low_power_mode); endproperty
  a_fall: assert property (p_fall) else $error("fallback off a sequence tick");
  property p_restart; sequence_restart |=> !sequence_restart; endproperty
  a_restart: assert property (p_restart) else $error("restart not a pulse");
  property p_level; near_recal_level_eff[3:0] == 4'h0; endproperty
  a_level: assert property (p_level) else $error("level not times 16");
  property p_rate; near_detect_rate_eff[3:0] == 4'h0; endproperty
  a_rate: assert property (p_rate) else $error("rate not times 16");
  // a lone source rising must move the pin while stage conditions sit still
  property p_irq; $rose(other_irq) && stage_low_exceeded == '0 && $stable(stage_low_exceeded) |=> $changed(irq_pin);
  endproperty
  a_irq: assert property (p_irq) else $error("pin ignored other source");
endmodule
bind ambient_comp_ctrl_regs amb_comp_props #(.STAGES(STAGES)) i_props (.clock, .rst_n, .sequence_done,
  .low_power_mode, .near_detect, .fast_filter_admit, .cal_hold, .power_fallback, .sequence_restart,
  .near_recal_level_eff, .near_detect_rate_eff, .stage_low_exceeded, .other_irq, .irq_pin);

// ---- verif/serial_host.sv ----
// serial bus host model that writes and reads register words
`timescale 1ns/1ps
module serial_host #(
  parameter logic [6:0] ADDR = 7'h2a // arbitrary device address
) (
  // clock
  input wire logic clock,
  // bus lines, data pulled up outside
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // quarter bit of six clocks gives a 24-clock serial period
  task automatic q;
    repeat (6) @(posedge clock);
  endtask
  // data falls while the clock is high, also as repeated start
  task automatic start;
    sda_pull <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_pull <= 1'b1;
    q;
    scl <= 1'b0;
    q;
  endtask
  task automatic stop;
    sda_pull <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda_pull <= 1'b0;
    q;
  endtask
  // data only moves while the clock is low, sampled mid high phase
  task automatic xfer(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      sda_pull <= ~v[i];
      q;
      scl <= 1'b1;
      q;
      r[i] = sda_line;
      q;
      scl <= 1'b0;
      q;
    end
  endtask
  task automatic send(input logic [7:0] b);
    logic [8:0] r;
    xfer({b, 1'b1}, r);
  endtask
  task automatic point(input logic [9:0] p);
    start;
    send({ADDR, 1'b0});
    send({6'h0, p[9:8]});
    send(p[7:0]);
  endtask
  // high byte first, the word commits on the low byte
  task automatic write_word(input logic [9:0] p, input logic [15:0] w);
    point(p);
    send(w[15:8]);
    send(w[7:0]);
    stop;
  endtask
  task automatic read_word(input logic [9:0] p, output logic [15:0] w);
    logic [8:0] hi;
    logic [8:0] lo;
    point(p);
    start;
    send({ADDR, 1'b1});
    xfer(9'h1fe, hi);
    xfer(9'h1ff, lo);
    stop;
    w = {hi[8:1], lo[8:1]};
  endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the ambient compensation register bank
`timescale 1ns/1ps
module testbench;
  import amb_comp_pkg::*;
  typedef struct {
    logic [9:0] ofs;
    logic [15:0] wr;
    logic [15:0] rd;
  } row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sequence_done = 1'b0;
  logic low_power_mode = 1'b0;
  logic near_detect = 1'b0;
  logic other_irq = 1'b0;
  logic gpio_in = 1'b0;
  logic gpio_assert = 1'b0;
  logic [7:0] stage_low_exceeded = 8'h00;
  logic scl, sda_pull, sda_oe, sda_out, sda_line, fast_filter_admit, cal_hold, power_fallback;
  logic force_recal_all, sequence_restart, irq_pin, gpio_out, gpio_oe, gpio_event;
  logic [11:0] near_recal_level_eff;
  logic [9:0] near_detect_rate_eff, full_power_recal_time;
  logic [5:0] low_power_recal_time;
  logic [1:0] slow_filter_update_level;
  logic [15:0] d;
  int error_cnt = 0;
  int checks = 0;
  int admits = 0;
  int falls = 0;
  int restarts = 0;
  int events = 0;
  row_t rows [5] = '{'{10'h002, 16'h6af3, 16'h6af3}, '{10'h003, 16'h8325, 16'h8325},
    '{10'h004, 16'h5a5a, 16'h5a5a}, '{10'h005, 16'h50a5, 16'h50a5}, '{10'h3ff, 16'h1234, 16'h0000}};
  logic [15:0] defs [4] = '{16'h0ff0, 16'h0140, 16'hffff, 16'h0000};
  always #12.5 clock = ~clock;
  // open-drain data line with pull-up
  assign sda_line = ~(sda_oe | sda_pull);
  ambient_comp_ctrl_regs i_ambient_comp_ctrl_regs (.clock, .rst_n, .scl_in(scl), .sda_in(sda_line),
    .sda_out, .sda_oe, .sequence_done, .low_power_mode, .near_detect, .fast_filter_admit, .cal_hold,
    .power_fallback, .force_recal_all, .sequence_restart, .near_recal_level_eff, .near_detect_rate_eff,
    .slow_filter_update_level, .full_power_recal_time, .low_power_recal_time, .stage_low_exceeded,
    .other_irq, .irq_pin, .gpio_in, .gpio_assert, .gpio_out, .gpio_oe, .gpio_event);
  serial_host host (.clock, .sda_line, .scl, .sda_pull);
  // pulses are counted so a one-cycle output is never missed
  always @(posedge clock)
  begin
    if (fast_filter_admit === 1'b1)
      admits++;
    if (power_fallback === 1'b1)
      falls++;
    if (sequence_restart === 1'b1)
      restarts++;
    if (gpio_event === 1'b1)
      events++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // finished sequences spaced so each pulse is seen alone
  task automatic seqs(input int n);
    repeat (n)
    begin
      sequence_done <= 1'b1;
      @(posedge clock);
      sequence_done <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  initial
  begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    test_done;
  end
  // --------------------------------
  // main sequence
  // --------------------------------
  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    check({11'h0, sda_out, cal_hold, gpio_oe, sda_oe, irq_pin}, 16'h1);
    foreach (rows[i])
    begin
      host.write_word(rows[i].ofs, rows[i].wr);
      host.read_word(rows[i].ofs, d);
      check(d, rows[i].rd);
    end
    check({1'b0, force_recal_all, slow_filter_update_level, near_recal_level_eff}, 16'h6250);
    check({near_detect_rate_eff, low_power_recal_time}, {10'h030, 6'h16});
    check({6'h0, full_power_recal_time}, 16'h025a);
    host.write_word(10'h000, 16'h0400);
    foreach (defs[i])
    begin
      host.read_word(10'(i + 2), d);
      check(d, defs[i]);
    end
    host.write_word(10'h002, 16'h8ff1);
    host.read_word(10'h002, d);
    check(d, 16'h0ff1);
    check(16'(restarts), 16'h1);
    admits = 0;
    seqs(6);
    check(16'(admits), 16'h3);
    host.write_word(10'h002, 16'h8ffb);
    admits = 0;
    seqs(9);
    check(16'(admits), 16'h1);
    seqs(1);
    check(16'(admits), 16'h2);
    // every timeout code, hold of one count in full power
    for (int c = 0; c < 4; c++)
    begin
      host.write_word(10'h002, {2'h0, 2'(c), 12'h110});
      falls = 0;
      near_detect <= 1'b1;
      @(posedge clock);
      near_detect <= 1'b0;
      seqs(15);
      check({15'h0, cal_hold}, 16'h1);
      seqs(1);
      check({15'h0, cal_hold}, 16'h0);
      seqs(4 * c + 3);
      check(16'(falls), 16'h0);
      seqs(1);
      check(16'(falls), 16'h1);
    end
    low_power_mode <= 1'b1;
    near_detect <= 1'b1;
    @(posedge clock);
    near_detect <= 1'b0;
    seqs(3);
    check({15'h0, cal_hold}, 16'h1);
    seqs(1);
    check({15'h0, cal_hold}, 16'h0);
    low_power_mode <= 1'b0;
    host.write_word(10'h005, 16'h0008);
    stage_low_exceeded <= 8'h04;
    repeat (3) @(posedge clock);
    check({15'h0, irq_pin}, 16'h1);
    stage_low_exceeded <= 8'h08;
    repeat (3) @(posedge clock);
    check({15'h0, irq_pin}, 16'h0);
    stage_low_exceeded <= 8'h00;
    repeat (3) @(posedge clock);
    other_irq <= 1'b1;
    repeat (3) @(posedge clock);
    check({15'h0, irq_pin}, 16'h0);
    host.write_word(10'h000, 16'h0800);
    check({15'h0, irq_pin}, 16'h1);
    other_irq <= 1'b0;
    gpio_assert <= 1'b1;
    host.write_word(10'h005, 16'h3000);
    check({14'h0, gpio_oe, gpio_out}, 16'h3);
    host.write_word(10'h005, 16'h2000);
    check({14'h0, gpio_oe, gpio_out}, 16'h2);
    gpio_in <= 1'b1;
    host.write_word(10'h005, 16'hd000);
    check({14'h0, gpio_oe, gpio_event}, 16'h1);
    host.write_word(10'h005, 16'h9000);
    events = 0;
    gpio_in <= 1'b0;
    repeat (8) @(posedge clock);
    host.write_word(10'h005, 16'h5000);
    gpio_in <= 1'b1;
    repeat (8) @(posedge clock);
    check(16'(events), 16'h2);
    host.write_word(10'h005, 16'h1000);
    check({15'h0, gpio_event}, 16'h0);
    test_done;
  end
endmodule
